// ---- flash_host_defs.svh ----
// timing counts and pin field positions for the flash bus host
//
// Functional notes
// - read needs chip select and output gate low, write strobe and reset high.
// - host writes with write strobe and chip select low, output gate high.
// - leaving standby, host allows the full chip-enable access time.
// - host flags a program or erase cut short by reset, for the user to reissue.
// - idle reset completes quickly; host waits recovery time before reading.
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define CLK_NS 8
`define TMR_W 12

// electrical times in ns, plain defaults
`define T_ACC_NS 150
`define T_WSETUP_NS 20
`define T_WPULSE_NS 50
`define T_WHOLD_NS 20
`define T_RP_NS 500
`define T_RH_NS 50
`define T_READY_NS 20000

// pin input synchroniser latency, in cycles
`define SYNC_CYC 2

// least times round up to whole cycles
`define CYC_ACC ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_WSETUP ((`T_WSETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_WPULSE ((`T_WPULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_WHOLD ((`T_WHOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_RP ((`T_RP_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_RH ((`T_RH_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_READY ((`T_READY_NS + `CLK_NS - 1) / `CLK_NS)

// pin field positions
`define TOP_DQ_BIT 15
`define SECT_HI 17
`define SECT_LO 12

`endif

// ---- flash_host_pkg.sv ----
// types shared by the flash bus host modules
package flash_host_pkg;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_RESET = 2'h2,
        OP_NONE = 2'h3
    } op_type;

    typedef enum logic [3:0] {
        ST_BOOT = 4'h0,
        ST_IDLE = 4'h1,
        ST_RD = 4'h2,
        ST_WR_SET = 4'h3,
        ST_WR_PULSE = 4'h4,
        ST_WR_HOLD = 4'h5,
        ST_RST_LOW = 4'h6,
        ST_RST_WAIT = 4'h7,
        ST_RST_REC = 4'h8
    } state_type;

endpackage

// ---- flash_tmr_if.sv ----
// phase timer hookup between the sequencer and its down counter
`timescale 1ns/1ps
`include "flash_host_defs.svh"
interface flash_tmr_if;
    logic load;
    logic [`TMR_W-1:0] cycles;
    logic expired;

    modport ctrl (output load, output cycles, input expired);
    modport tmr (input load, input cycles, output expired);
endinterface

// ---- flash_phase_timer.sv ----
// down counter that times each bus phase
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_phase_timer (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // sequencer side
    flash_tmr_if.tmr tmr
);
    logic [`TMR_W-1:0] count_ff;
    logic [`TMR_W-1:0] nxt_count;

    // reload on phase change, else count down and stop at zero
    assign nxt_count = tmr.load ? tmr.cycles :
                       (count_ff != '0) ? count_ff - `TMR_W'(1) : count_ff;
    // expiry looks at the count only; gating it with load would close a
    // zero-delay loop through the sequencer's next-state logic
    assign tmr.expired = (count_ff == '0);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end
endmodule

// ---- flash_bus_host.sv ----
// host-side sequencer driving the parallel flash pins
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_bus_host
    import flash_host_pkg::*;
#(
    parameter int TMR_W = `TMR_W
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // user request
    input wire logic i_req,
    input wire op_type i_op,
    input wire logic [18:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_byte_mode,
    // user answer
    output logic o_ready,
    output logic o_rvalid,
    output logic [15:0] o_rdata,
    output logic o_done,
    output logic o_abort_seen,
    output logic o_dev_busy,
    output logic [3:0] o_sector,
    // flash pins
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_flash_reset_n,
    output logic o_byte_n,
    output logic [17:0] o_addr,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic [15:0] o_dq_oe,
    input wire logic i_rdy_bsy
);
    // counts that do not fit the timer cannot be served
    if (`CYC_READY >= (1 << TMR_W) || TMR_W != `TMR_W) begin : g_chk
        $error("phase timer too narrow for the timing counts");
    end

    state_type state_ff, nxt_state;
    logic [18:0] addr_ff;
    logic [15:0] wdata_ff, rdata_ff, dq_s1_ff, dq_s2_ff;
    logic byte_ff, rb_s1_ff, rb_s2_ff, abort_ff, nxt_abort;
    logic ce_n_ff, oe_n_ff, we_n_ff, rst_n_ff, rvalid_ff, done_ff;
    logic [15:0] dq_oe_ff, dq_ff;
    logic [3:0] sector_ff;
    logic take, dev_ready;
    logic [TMR_W-1:0] nxt_cycles;

    flash_tmr_if tmr_bus();

    flash_phase_timer u_timer (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .tmr(tmr_bus.tmr)
    );

    // top-boot sector index from address bits 17..12
    function automatic logic [3:0] sector_of(input logic [5:0] a);
        logic [3:0] s;
        s = 4'hA;
        if (a[5:3] != 3'h7) begin
            s = {1'b0, a[5:3]};
        end else if (!a[2]) begin
            s = 4'h7;
        end else if (!a[1]) begin
            s = a[0] ? 4'h9 : 4'h8;
        end
        return s;
    endfunction

    // pin inputs pass two flops; the first is read by the second only
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dq_s1_ff <= 16'h0000;
            dq_s2_ff <= 16'h0000;
            rb_s1_ff <= 1'b1;
            rb_s2_ff <= 1'b1;
        end else begin
            dq_s1_ff <= i_dq;
            dq_s2_ff <= dq_s1_ff;
            rb_s1_ff <= i_rdy_bsy;
            rb_s2_ff <= rb_s1_ff;
        end
    end

    assign dev_ready = rb_s2_ff;
    assign take = (state_ff == ST_IDLE) && i_req && (i_op != OP_NONE);

    // next phase; every idle gap deselects, so each read pays full t_CE
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_BOOT: nxt_state = ST_RST_LOW;
            ST_IDLE: begin
                if (take) begin
                    case (i_op)
                        OP_READ: nxt_state = ST_RD;
                        OP_WRITE: nxt_state = ST_WR_SET;
                        default: nxt_state = ST_RST_LOW;
                    endcase
                end
            end
            ST_RD: if (tmr_bus.expired) nxt_state = ST_IDLE;
            ST_WR_SET: if (tmr_bus.expired) nxt_state = ST_WR_PULSE;
            ST_WR_PULSE: if (tmr_bus.expired) nxt_state = ST_WR_HOLD;
            ST_WR_HOLD: if (tmr_bus.expired) nxt_state = ST_IDLE;
            ST_RST_LOW: if (tmr_bus.expired) nxt_state = ST_RST_WAIT;
            // leave once the busy pin reads ready, or when the ready timeout count runs out
            ST_RST_WAIT: if (dev_ready || tmr_bus.expired) nxt_state = ST_RST_REC;
            ST_RST_REC: if (tmr_bus.expired) nxt_state = ST_IDLE;
            default: nxt_state = ST_BOOT;
        endcase
    end

    // full access time per read
    // phase lengths; read adds the synchroniser delay on top of t_CE
    always_comb begin
        case (nxt_state)
            ST_RD: nxt_cycles = TMR_W'(`CYC_ACC + `SYNC_CYC);
            ST_WR_SET: nxt_cycles = TMR_W'(`CYC_WSETUP);
            ST_WR_PULSE: nxt_cycles = TMR_W'(`CYC_WPULSE);
            ST_WR_HOLD: nxt_cycles = TMR_W'(`CYC_WHOLD);
            ST_RST_LOW: nxt_cycles = TMR_W'(`CYC_RP);
            ST_RST_WAIT: nxt_cycles = TMR_W'(`CYC_READY);
            ST_RST_REC: nxt_cycles = TMR_W'(`CYC_RH);
            default: nxt_cycles = '0;
        endcase
    end

    assign tmr_bus.load = (nxt_state != state_ff);
    assign tmr_bus.cycles = nxt_cycles;

    // remember a reset that landed on a running program or erase;
    // a reset request is itself a take, so the set test must come first
    assign nxt_abort = (nxt_state == ST_RST_LOW && state_ff != ST_RST_LOW) ? !dev_ready :
                       take ? 1'b0 : abort_ff;

    // request capture and sequencer state
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ST_BOOT;
            addr_ff <= 19'h00000;
            wdata_ff <= 16'h0000;
            byte_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            abort_ff <= nxt_abort;
            if (take) begin
                addr_ff <= i_addr;
                wdata_ff <= i_wdata;
                byte_ff <= i_byte_mode;
            end
        end
    end

    // read and write pin levels, output gate kept high except in a read
    // pin levels decoded from the coming phase so pins leave flops
    wire rd_phase = (nxt_state == ST_RD);
    wire wr_phase = (nxt_state == ST_WR_SET) || (nxt_state == ST_WR_PULSE)
                    || (nxt_state == ST_WR_HOLD);
    wire nxt_ce_n = !(rd_phase || wr_phase);
    wire nxt_oe_n = !rd_phase;
    wire nxt_we_n = (nxt_state != ST_WR_PULSE);
    wire nxt_rst_n = (nxt_state != ST_RST_LOW) && (nxt_state != ST_BOOT);
    wire nxt_byte = take ? i_byte_mode : byte_ff;
    wire [18:0] nxt_addr = take ? i_addr : addr_ff;
    wire [15:0] nxt_wdata = take ? i_wdata : wdata_ff;
    // byte mode drives the top pin as lowest address bit
    wire [15:0] lane_oe = nxt_byte ? 16'h00FF : 16'hFFFF;
    wire [15:0] nxt_dq_oe = (wr_phase ? lane_oe : 16'h0000)
                            | (nxt_byte ? 16'h8000 : 16'h0000);
    wire [15:0] nxt_dq = nxt_byte ? {nxt_addr[0], 7'h00, nxt_wdata[7:0]} : nxt_wdata;
    // word address sits above the byte lane select
    wire [17:0] nxt_pin_addr = nxt_addr[18:1];

    // pin and answer flops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            rst_n_ff <= 1'b0;
            dq_oe_ff <= 16'h0000;
            dq_ff <= 16'h0000;
            sector_ff <= 4'h0;
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            ce_n_ff <= nxt_ce_n;
            oe_n_ff <= nxt_oe_n;
            we_n_ff <= nxt_we_n;
            rst_n_ff <= nxt_rst_n;
            dq_oe_ff <= nxt_dq_oe;
            dq_ff <= nxt_dq;
            sector_ff <= sector_of(nxt_pin_addr[`SECT_HI:`SECT_LO]);
            rvalid_ff <= (state_ff == ST_RD) && tmr_bus.expired;
            done_ff <= tmr_bus.expired
                       && (state_ff == ST_WR_HOLD || state_ff == ST_RST_REC);
            if ((state_ff == ST_RD) && tmr_bus.expired) begin
                rdata_ff <= byte_ff ? {8'h00, dq_s2_ff[7:0]} : dq_s2_ff;
            end
        end
    end

    // address pins held in their own flop bank
    logic [17:0] pin_addr_ff;
    logic pin_byte_n_ff;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_addr_ff <= 18'h00000;
            pin_byte_n_ff <= 1'b1;
        end else begin
            pin_addr_ff <= nxt_pin_addr;
            pin_byte_n_ff <= !nxt_byte;
        end
    end

    assign o_ready = (state_ff == ST_IDLE);
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_done = done_ff;
    // flags a reset that cut an operation short
    assign o_abort_seen = abort_ff;
    assign o_dev_busy = !dev_ready;
    assign o_sector = sector_ff;
    assign o_ce_n = ce_n_ff;
    assign o_oe_n = oe_n_ff;
    assign o_we_n = we_n_ff;
    assign o_flash_reset_n = rst_n_ff;
    assign o_byte_n = pin_byte_n_ff;
    assign o_addr = pin_addr_ff;
    assign o_dq = dq_ff;
    assign o_dq_oe = dq_oe_ff;

    // cycles since chip select fell, for the access-time check
    logic [TMR_W-1:0] acc_cnt_ff;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_cnt_ff <= '0;
        end else if (o_ce_n) begin
            acc_cnt_ff <= '0;
        end else if (acc_cnt_ff != '1) begin
            acc_cnt_ff <= acc_cnt_ff + TMR_W'(1);
        end
    end

    sequence s_reset_into_busy;
        $fell(o_flash_reset_n) && o_dev_busy;
    endsequence

    sequence s_reset_released;
        $rose(o_flash_reset_n);
    endsequence

    a_read_pin_levels: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!o_oe_n) |-> (!o_ce_n && o_we_n && o_flash_reset_n && (o_dq_oe[7:0] == 8'h00)))
        else $error("read issued with wrong control levels");

    a_write_gate_high: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!o_we_n) |-> (!o_ce_n && o_oe_n && o_dq_oe[0]))
        else $error("write strobe low without select or with output gate low");

    a_write_data_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_we_n) |-> (!o_ce_n && $stable(o_dq) && $stable(o_addr)))
        else $error("write data or address moved at strobe rise");

    a_read_access_time: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_rvalid) |-> (acc_cnt_ff > TMR_W'(`CYC_ACC)))
        else $error("read data taken before chip-enable access time");

    a_reset_abort_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_reset_into_busy |=> o_abort_seen)
        else $error("reset during busy not flagged for reissue");

    a_reset_recovery: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_reset_released |=> (!o_ready && o_oe_n && o_we_n)[*7])
        else $error("access started inside reset recovery time");
endmodule

// ---- flash_dev_model.sv ----
// behavioural flash device answering the host pins
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_dev_model #(
    parameter int PROG_NS = 1000,
    parameter int ABORT_NS = 2000,
    parameter logic [7:0] STATUS = 8'h5A
) (
    // control pins
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_reset_n,
    input wire logic i_byte_n,
    // address and data
    input wire logic [17:0] i_addr,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic [15:0] o_dq_oe,
    output logic o_rdy_bsy
);
    logic [7:0] mem [int];
    logic [15:0] pat = 16'hA5C3;
    logic [18:0] wa;
    logic [15:0] wd;
    logic bm;
    time t_chg = 0;
    wire rd_en = !i_ce_n && !i_oe_n && i_we_n && i_reset_n;
    wire wr_en = !i_ce_n && !i_we_n && i_oe_n && i_reset_n;
    // top pin is the low address bit in byte mode
    wire [18:0] ba = {i_addr, !i_byte_n && i_dq[15]};

    initial o_rdy_bsy = 1'b1;

    // erased cells read as all ones
    function automatic logic [7:0] rd8(input int a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction

    // access time counts from the last change
    always @(rd_en or ba or i_byte_n) t_chg = $time;

    assign o_dq_oe = !rd_en ? 16'h0000 : (i_byte_n ? 16'hFFFF : 16'h00FF);

    // undriven lanes churn so stale data never looks valid
    always #1 begin
        pat = {pat[14:0], ~pat[15]};
        if (!rd_en || $time - t_chg < `T_ACC_NS) o_dq = pat;
        else if (!o_rdy_bsy) o_dq = {pat[15:8], STATUS};
        else if (i_byte_n) o_dq = {rd8(ba + 1), rd8(ba)};
        else o_dq = {pat[15:8], rd8(ba)};
    end

    // address on the later falling strobe
    always @(posedge wr_en) begin
        wa = ba;
        bm = !i_byte_n;
    end

    // data on the earlier rising strobe
    always @(negedge wr_en) if (o_rdy_bsy && i_reset_n) begin : prog
        wd = i_dq;
        o_rdy_bsy = 1'b0;
        #(PROG_NS);
        mem[wa] = wd[7:0];
        if (!bm) mem[wa + 1] = wd[15:8];
        o_rdy_bsy = 1'b1;
    end

    // reset kills a program, busy lingers
    always @(negedge i_reset_n) if (!o_rdy_bsy) begin
        disable prog;
        #(ABORT_NS);
        o_rdy_bsy = 1'b1;
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the flash bus host against the device model
`timescale 1ns/1ps
module testbench;
    import flash_host_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic req = 1'b0;
    op_type op = OP_NONE;
    logic [18:0] addr = '0;
    logic [15:0] wdata = '0;
    logic bm = 1'b0;
    logic o_ready, o_rvalid, o_done, o_abort_seen, o_dev_busy;
    logic o_ce_n, o_oe_n, o_we_n, o_flash_reset_n, o_byte_n, rdy;
    logic [15:0] o_rdata, o_dq, o_dq_oe, dev_dq, dev_oe, rd, d;
    logic [3:0] o_sector;
    logic [17:0] o_addr;
    logic [18:0] a;
    logic [7:0] shadow [int];
    logic [18:0] corner [10] = '{19'h00000, 19'h6FFFF, 19'h70000, 19'h77FFF, 19'h78000,
        19'h79FFF, 19'h7A000, 19'h7BFFF, 19'h7C000, 19'h7FFFF};
    int n_fail = 0;
    int n_checks = 0;
    int seed = 32'h0B43C944;
    int cyc = 0;
    // resolved data pins: host wins where it drives
    wire [15:0] dq = (o_dq & o_dq_oe) | (dev_dq & ~o_dq_oe);

    flash_bus_host dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_req(req), .i_op(op),
        .i_addr(addr), .i_wdata(wdata), .i_byte_mode(bm), .o_ready(o_ready),
        .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_done(o_done),
        .o_abort_seen(o_abort_seen), .o_dev_busy(o_dev_busy), .o_sector(o_sector),
        .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
        .o_flash_reset_n(o_flash_reset_n), .o_byte_n(o_byte_n), .o_addr(o_addr),
        .i_dq(dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_rdy_bsy(rdy));

    flash_dev_model dev (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_reset_n(o_flash_reset_n), .i_byte_n(o_byte_n), .i_addr(o_addr), .i_dq(dq),
        .o_dq(dev_dq), .o_dq_oe(dev_oe), .o_rdy_bsy(rdy));

    // free-running clock, 8 ns period
    initial begin
        forever #4 i_clk = ~i_clk;
    end

    function automatic logic [7:0] sb(input int x);
        return shadow.exists(x) ? shadow[x] : 8'hFF;
    endfunction

    // byte reads come back zero-extended
    function automatic logic [15:0] exp_rd(input logic [18:0] x, input logic b);
        return b ? {8'h00, sb(x)} : {sb({x[18:1], 1'b1}), sb({x[18:1], 1'b0})};
    endfunction

    // top-boot sector index from pins A17..A12
    function automatic logic [3:0] exp_sect(input logic [17:0] p);
        if (p[17:15] != 3'h7) return {1'b0, p[17:15]};
        if (!p[14]) return 4'h7;
        if (p[13]) return 4'hA;
        return p[12] ? 4'h9 : 4'h8;
    endfunction

    task automatic chk(input string what, input logic [18:0] e, input logic [18:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic summarize;
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one request, then wait for its answer; pins are probed mid-read
    task automatic do_op(input op_type o, input logic [18:0] x, input logic [15:0] v,
                         input logic b);
        int k;
        k = 0;
        while (o_ready !== 1'b1 && k < 3000) begin
            @(negedge i_clk);
            k++;
        end
        @(posedge i_clk);
        req <= 1'b1;
        op <= o;
        addr <= x;
        wdata <= v;
        bm <= b;
        @(posedge i_clk);
        req <= 1'b0;
        k = 0;
        do begin
            @(negedge i_clk);
            k++;
            if (k == 6 && o == OP_READ) begin
                chk("pin ctl", 0, {o_ce_n, o_oe_n, !o_we_n, !o_flash_reset_n});
                chk("pin addr", x[18:1], o_addr);
                chk("sector", exp_sect(x[18:1]), o_sector);
                chk("width pin", !b, o_byte_n);
                chk("host oe", b ? 19'h8000 : 19'h0, o_dq_oe);
                if (b) chk("low addr pin", x[0], o_dq[15]);
            end
        end while (o_rvalid !== 1'b1 && o_done !== 1'b1 && k < 3000);
        if (k >= 3000) chk("answer", 1, 0);
        rd = o_rdata;
    endtask

    task automatic wr(input logic [18:0] x, input logic [15:0] v, input logic b);
        do_op(OP_WRITE, x, v, b);
        shadow[b ? x : {x[18:1], 1'b0}] = v[7:0];
        if (!b) shadow[{x[18:1], 1'b1}] = v[15:8];
    endtask

    // wait out a running program, bounded
    task automatic settle;
        int k;
        k = 0;
        while (o_dev_busy !== 1'b0 && k < 400) begin
            @(negedge i_clk);
            k++;
        end
    endtask

    // overlap and hang watch, once a cycle between edges
    always @(negedge i_clk) begin
        cyc++;
        if (i_resetn) begin
            chk("strobe overlap", 0, !o_oe_n && !o_we_n);
            chk("bus clash", 0, o_dq_oe & dev_oe);
        end
        if (cyc > 40000) begin
            n_fail++;
            summarize;
        end
    end

    initial begin
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        // untouched array after power-up
        for (int i = 0; i < 4; i++) begin
            a = 19'($random(seed));
            do_op(OP_READ, a, 16'h0, i[0]);
            chk("boot read", exp_rd(a, i[0]), rd);
        end
        // random programs, alternating width
        for (int i = 0; i < 12; i++) begin
            a = 19'($random(seed));
            d = 16'($random(seed));
            wr(a, d, i[0]);
            do_op(OP_READ, a, 16'h0, i[0]);
            chk("status", 8'h5A, rd[7:0]);
            settle;
            do_op(OP_READ, a, 16'h0, i[0]);
            chk("array read", exp_rd(a, i[0]), rd);
            do_op(OP_READ, a ^ 19'h1, 16'h0, i[0]);
            chk("neighbour", exp_rd(a ^ 19'h1, i[0]), rd);
        end
        // sector boundaries of the top-boot map
        foreach (corner[i]) begin
            do_op(OP_READ, corner[i], 16'h0, 1'b1);
            chk("corner read", exp_rd(corner[i], 1'b1), rd);
        end
        // hardware reset landing on a running program
        a = 19'h7C002;
        d = 16'h1234;
        do_op(OP_WRITE, a, d, 1'b0);
        do_op(OP_RESET, 19'h0, 16'h0, 1'b0);
        chk("abort flag", 1, o_abort_seen);
        do_op(OP_READ, a, 16'h0, 1'b0);
        chk("aborted data", exp_rd(a, 1'b0), rd);
        wr(a, d, 1'b0);
        settle;
        do_op(OP_RESET, 19'h0, 16'h0, 1'b0);
        chk("idle reset flag", 0, o_abort_seen);
        do_op(OP_READ, a, 16'h0, 1'b0);
        chk("reissued data", exp_rd(a, 1'b0), rd);
        summarize;
    end
endmodule
